// file: core/csf_pkg.sv
package csf_pkg;

  localparam logic [7:0] CSF_FLAGS_OFFSET = 8'h00;
  localparam logic [7:0] CSF_RESULT_OFFSET = 8'h04;

  localparam int unsigned CSF_BIT_TIMEOUT = 4;
  localparam int unsigned CSF_BIT_POWERDOWN = 3;
  localparam int unsigned CSF_BIT_ZERO = 2;
  localparam int unsigned CSF_BIT_HALF = 1;
  localparam int unsigned CSF_BIT_CARRY = 0;

  // Power-up: timeout and power-down set, arithmetic flags clear
  localparam logic [7:0] CSF_FLAGS_RESET = 8'h18;
  localparam logic [7:0] CSF_RESULT_RESET = 8'h00;

  localparam logic [1:0] CSF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSF_RESP_SLVERR = 2'h2;

  localparam logic [1:0] CSF_HIT_NONE = 2'h0;
  localparam logic [1:0] CSF_HIT_FLAGS = 2'h1;
  localparam logic [1:0] CSF_HIT_RESULT = 2'h2;

  typedef enum logic [4:0] {
    CSF_NOP = 5'h00,
    CSF_ADD_REG_INSTR = 5'h01,
    CSF_ADD_LITERAL_INSTR = 5'h02,
    CSF_SUB_LITERAL_INSTR = 5'h03,
    CSF_SUB_REG_INSTR = 5'h04,
    CSF_AND_INSTR = 5'h05,
    CSF_OR_INSTR = 5'h06,
    CSF_XOR_INSTR = 5'h07,
    CSF_INC_INSTR = 5'h08,
    CSF_DEC_INSTR = 5'h09,
    CSF_ROTATE_RIGHT_INSTR = 5'h0a,
    CSF_ROTATE_LEFT_INSTR = 5'h0b,
    CSF_BIT_CLEAR_INSTR = 5'h0c,
    CSF_BIT_SET_INSTR = 5'h0d,
    CSF_NIBBLE_SWAP_INSTR = 5'h0e,
    CSF_MOVE_W_TO_REG_INSTR = 5'h0f,
    CSF_REG_CLEAR_INSTR = 5'h10,
    CSF_WATCHDOG_CLEAR_INSTR = 5'h11,
    CSF_SLEEP_INSTR = 5'h12
  } csf_op_t;

  typedef struct packed {
    csf_op_t op;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
    logic dest_status;
  } csf_exec_t;

  typedef struct packed {
    logic zero;
    logic half_carry;
    logic carry;
  } csf_affect_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] result;
  } csf_regs_t;

  function automatic logic [1:0] csf_decode(input logic [7:0] addr);
    logic [1:0] hit;
    hit = CSF_HIT_NONE;
    if (addr[7:2] == CSF_FLAGS_OFFSET[7:2]) begin
      hit = CSF_HIT_FLAGS;
    end else if (addr[7:2] == CSF_RESULT_OFFSET[7:2]) begin
      hit = CSF_HIT_RESULT;
    end
    return hit;
  endfunction

  function automatic logic [31:0] csf_read_word(input logic [7:0] addr,
                                                input csf_regs_t regs);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (csf_decode(addr))
      CSF_HIT_FLAGS: word = {24'h00_0000, regs.flags};
      CSF_HIT_RESULT: word = {24'h00_0000, regs.result};
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction

endpackage

// file: core/csf_flag_alu.sv
`timescale 1ns/1ps
module csf_flag_alu
  import csf_pkg::*;
(
  input wire csf_exec_t exec_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic zero_out,
  output logic half_carry_out,
  output logic carry_out,
  output csf_affect_t affect_out,
  output logic writes_dest_out
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] mask;
  logic [7:0] b_eff;
  logic sub;

  always_comb begin
    sub = (exec_in.op == CSF_SUB_REG_INSTR) ||
          (exec_in.op == CSF_SUB_LITERAL_INSTR);
    // Subtract as a + ~b + 1, so carries read as inverted borrows
    b_eff = sub ? ~exec_in.operand_b : exec_in.operand_b;
    sum = {1'b0, exec_in.operand_a} + {1'b0, b_eff} + {8'h00, sub};
    nib = {1'b0, exec_in.operand_a[3:0]} + {1'b0, b_eff[3:0]} +
          {4'h0, sub};
    mask = 8'h01 << exec_in.operand_b[2:0];
    result_out = exec_in.operand_a;
    carry_out = carry_in;
    affect_out = '0;
    writes_dest_out = 1'b1;
    case (exec_in.op)
      CSF_ADD_REG_INSTR, CSF_SUB_REG_INSTR,
      CSF_ADD_LITERAL_INSTR, CSF_SUB_LITERAL_INSTR: begin
        result_out = sum[7:0];
        carry_out = sum[8];
        affect_out = 3'b111;
        writes_dest_out = (exec_in.op == CSF_ADD_REG_INSTR) ||
                          (exec_in.op == CSF_SUB_REG_INSTR);
      end
      CSF_AND_INSTR: begin
        result_out = exec_in.operand_a & exec_in.operand_b;
        affect_out.zero = 1'b1;
      end
      CSF_OR_INSTR: begin
        result_out = exec_in.operand_a | exec_in.operand_b;
        affect_out.zero = 1'b1;
      end
      CSF_XOR_INSTR: begin
        result_out = exec_in.operand_a ^ exec_in.operand_b;
        affect_out.zero = 1'b1;
      end
      CSF_INC_INSTR: begin
        result_out = exec_in.operand_a + 8'h01;
        affect_out.zero = 1'b1;
      end
      CSF_DEC_INSTR: begin
        result_out = exec_in.operand_a - 8'h01;
        affect_out.zero = 1'b1;
      end
      CSF_ROTATE_RIGHT_INSTR: begin
        result_out = {carry_in, exec_in.operand_a[7:1]};
        carry_out = exec_in.operand_a[0];
        affect_out.carry = 1'b1;
      end
      CSF_ROTATE_LEFT_INSTR: begin
        result_out = {exec_in.operand_a[6:0], carry_in};
        carry_out = exec_in.operand_a[7];
        affect_out.carry = 1'b1;
      end
      CSF_BIT_CLEAR_INSTR: result_out = exec_in.operand_a & ~mask;
      CSF_BIT_SET_INSTR: result_out = exec_in.operand_a | mask;
      CSF_NIBBLE_SWAP_INSTR: begin
        result_out = {exec_in.operand_a[3:0], exec_in.operand_a[7:4]};
      end
      CSF_MOVE_W_TO_REG_INSTR: result_out = exec_in.operand_a;
      CSF_REG_CLEAR_INSTR: begin
        result_out = 8'h00;
        affect_out.zero = 1'b1;
      end
      default: writes_dest_out = 1'b0;
    endcase
    zero_out = (result_out == 8'h00);
    half_carry_out = nib[4];
  end

endmodule

// file: core/csf_axil_slave.sv
`timescale 1ns/1ps
module csf_axil_slave
  import csf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire csf_regs_t regs_in,
  output logic wr_pulse_out,
  output logic [7:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out
);

  typedef enum logic [2:0] {
    CSF_ST_IDLE = 3'b001,
    CSF_ST_WRESP = 3'b010,
    CSF_ST_RRESP = 3'b100
  } csf_axi_state_t;

  csf_axi_state_t state, next_state;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic awready, next_awready, wready, next_wready, arready, next_arready;
  logic [7:0] next_wr_addr;
  logic [31:0] next_wr_data;
  logic [3:0] next_wr_strb;
  logic next_wr_pulse, next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic aw_fire, w_fire, ar_fire;

  assign aw_fire = s_axi_awvalid_in && awready;
  assign w_fire = s_axi_wvalid_in && wready;
  assign ar_fire = s_axi_arvalid_in && arready;
  assign s_axi_awready_out = awready;
  assign s_axi_wready_out = wready;
  assign s_axi_arready_out = arready;

  always_comb begin
    next_state = state;
    next_aw_got = aw_got || aw_fire;
    next_w_got = w_got || w_fire;
    next_wr_addr = aw_fire ? s_axi_awaddr_in : wr_addr_out;
    next_wr_data = w_fire ? s_axi_wdata_in : wr_data_out;
    next_wr_strb = w_fire ? s_axi_wstrb_in : wr_strb_out;
    next_wr_pulse = 1'b0;
    next_bvalid = s_axi_bvalid_out;
    next_bresp = s_axi_bresp_out;
    next_rvalid = s_axi_rvalid_out;
    next_rresp = s_axi_rresp_out;
    next_rdata = s_axi_rdata_out;
    case (state)
      CSF_ST_IDLE: begin
        // A read taken alongside a write half is served first
        if (ar_fire) begin
          next_state = CSF_ST_RRESP;
          next_rvalid = 1'b1;
          next_rdata = csf_read_word(s_axi_araddr_in, regs_in);
          next_rresp = (csf_decode(s_axi_araddr_in) == CSF_HIT_NONE) ?
                       CSF_RESP_SLVERR : CSF_RESP_OKAY;
        end else if (next_aw_got && next_w_got) begin
          next_state = CSF_ST_WRESP;
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
          next_wr_pulse = 1'b1;
          next_bvalid = 1'b1;
          next_bresp = (csf_decode(next_wr_addr) == CSF_HIT_NONE) ?
                       CSF_RESP_SLVERR : CSF_RESP_OKAY;
        end
      end
      CSF_ST_WRESP: begin
        if (s_axi_bready_in) begin
          next_state = CSF_ST_IDLE;
          next_bvalid = 1'b0;
        end
      end
      CSF_ST_RRESP: begin
        if (s_axi_rready_in) begin
          next_state = CSF_ST_IDLE;
          next_rvalid = 1'b0;
        end
      end
      default: next_state = CSF_ST_IDLE;
    endcase
    next_awready = (next_state == CSF_ST_IDLE) && !next_aw_got;
    next_wready = (next_state == CSF_ST_IDLE) && !next_w_got;
    next_arready = (next_state == CSF_ST_IDLE) && !next_aw_got &&
                   !next_w_got;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= CSF_ST_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      wr_pulse_out <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 32'h0000_0000;
      wr_strb_out <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= CSF_RESP_OKAY;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= CSF_RESP_OKAY;
      s_axi_rdata_out <= 32'h0000_0000;
    end else begin
      state <= next_state;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      wr_pulse_out <= next_wr_pulse;
      wr_addr_out <= next_wr_addr;
      wr_data_out <= next_wr_data;
      wr_strb_out <= next_wr_strb;
      s_axi_bvalid_out <= next_bvalid;
      s_axi_bresp_out <= next_bresp;
      s_axi_rvalid_out <= next_rvalid;
      s_axi_rresp_out <= next_rresp;
      s_axi_rdata_out <= next_rdata;
    end
  end

endmodule

// file: core/core_status_flags.sv
`timescale 1ns/1ps
module core_status_flags
  import csf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic exec_valid_in,
  input wire csf_exec_t exec_in,
  input wire logic watchdog_timeout_in,
  output logic [7:0] flags_out,
  output logic [7:0] result_out,
  output logic result_valid_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  logic [7:0] flags, next_flags;
  logic [7:0] result, next_result;
  logic result_valid, next_result_valid;
  logic [7:0] alu_result;
  logic alu_zero, alu_half, alu_carry, alu_writes;
  csf_affect_t alu_affect;
  csf_regs_t regs;
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic sw_flag_write, reset_cause_set;

  assign flags_out = flags;
  assign result_out = result;
  assign result_valid_out = result_valid;
  assign regs = '{flags: flags, result: result};

  csf_flag_alu u_alu (
    .exec_in(exec_in),
    .carry_in(flags[CSF_BIT_CARRY]),
    .result_out(alu_result),
    .zero_out(alu_zero),
    .half_carry_out(alu_half),
    .carry_out(alu_carry),
    .affect_out(alu_affect),
    .writes_dest_out(alu_writes)
  );

  csf_axil_slave u_axil (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .regs_in(regs),
    .wr_pulse_out(wr_pulse),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb)
  );

  assign sw_flag_write = wr_pulse && wr_strb[0] &&
                         (csf_decode(wr_addr) == CSF_HIT_FLAGS);
  assign reset_cause_set = exec_valid_in &&
                           ((exec_in.op == CSF_WATCHDOG_CLEAR_INSTR) ||
                            (exec_in.op == CSF_SLEEP_INSTR));

  // Order matters: software write first, then timeout event, then instruction
  always_comb begin
    next_flags = flags;
    next_result = result;
    next_result_valid = 1'b0;
    // Software write only reaches the arithmetic flags
    if (sw_flag_write) begin
      next_flags[2:0] = wr_data[2:0];
    end
    // Timeout clear sits before the sets so a coincident set wins
    if (watchdog_timeout_in) begin
      next_flags[CSF_BIT_TIMEOUT] = 1'b0;
    end
    if (exec_valid_in) begin
      next_result = alu_result;
      next_result_valid = 1'b1;
      if (exec_in.dest_status && alu_writes) begin
        if (alu_affect == 3'b000) begin
          next_flags[2:0] = alu_result[2:0];
        end
      end
      if (alu_affect.zero) begin
        next_flags[CSF_BIT_ZERO] = alu_zero;
      end
      if (alu_affect.half_carry) begin
        next_flags[CSF_BIT_HALF] = alu_half;
      end
      if (alu_affect.carry) begin
        next_flags[CSF_BIT_CARRY] = alu_carry;
      end
      if (exec_in.op == CSF_WATCHDOG_CLEAR_INSTR) begin
        next_flags[CSF_BIT_TIMEOUT] = 1'b1;
        next_flags[CSF_BIT_POWERDOWN] = 1'b1;
      end
      if (exec_in.op == CSF_SLEEP_INSTR) begin
        next_flags[CSF_BIT_TIMEOUT] = 1'b1;
        next_flags[CSF_BIT_POWERDOWN] = 1'b0;
      end
    end
    next_flags[7:5] = 3'b000;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flags <= CSF_FLAGS_RESET;
      result <= CSF_RESULT_RESET;
      result_valid <= 1'b0;
    end else begin
      flags <= next_flags;
      result <= next_result;
      result_valid <= next_result_valid;
    end
  end

  default clocking cb_sys @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_upper_read_zero: assert property (
    (s_axi_rvalid_out && s_axi_rresp_out == CSF_RESP_OKAY) |->
      s_axi_rdata_out[31:8] == 24'h00_0000 && flags[7:5] == 3'b000)
    else $error("upper status bits read nonzero");

  a_cause_read_only: assert property (
    (sw_flag_write && !exec_valid_in && !watchdog_timeout_in) |=>
      $stable(flags[4:3]))
    else $error("software changed reset-cause flags");

  a_timeout_set: assert property (
    reset_cause_set |=> flags[CSF_BIT_TIMEOUT] ##1
      (flags[CSF_BIT_TIMEOUT] || $past(watchdog_timeout_in)))
    else $error("timeout flag not set by clear or sleep");

  a_timeout_clear: assert property (
    (watchdog_timeout_in && !reset_cause_set) |=> !flags[CSF_BIT_TIMEOUT])
    else $error("timeout flag not cleared by watchdog timeout");

  a_powerdown_track: assert property (
    (exec_valid_in && exec_in.op == CSF_SLEEP_INSTR) |=>
      !flags[CSF_BIT_POWERDOWN])
    else $error("power-down flag not cleared by sleep");

  a_powerdown_set: assert property (
    (exec_valid_in && exec_in.op == CSF_WATCHDOG_CLEAR_INSTR) |=>
      flags[CSF_BIT_POWERDOWN] && flags[CSF_BIT_TIMEOUT])
    else $error("watchdog clear did not set both cause flags");

  a_zero_result: assert property (
    (exec_valid_in && alu_affect.zero) |=>
      flags[CSF_BIT_ZERO] == (result == 8'h00))
    else $error("zero flag disagrees with result");

  a_add_carry: assert property (
    (exec_valid_in && exec_in.op == CSF_ADD_REG_INSTR) |=>
      flags[CSF_BIT_CARRY] == (({1'b0, $past(exec_in.operand_a)} +
        {1'b0, $past(exec_in.operand_b)}) > 9'h0ff))
    else $error("add carry wrong");

  a_add_half: assert property (
    (exec_valid_in && exec_in.op == CSF_ADD_LITERAL_INSTR) |=>
      flags[CSF_BIT_HALF] == (({1'b0, $past(exec_in.operand_a[3:0])} +
        {1'b0, $past(exec_in.operand_b[3:0])}) > 5'h0f))
    else $error("add half carry wrong");

  a_sub_borrow: assert property (
    (exec_valid_in && exec_in.op == CSF_SUB_REG_INSTR) |=>
      flags[CSF_BIT_CARRY] ==
        ($past(exec_in.operand_a) >= $past(exec_in.operand_b)) &&
      result == $past(exec_in.operand_a) - $past(exec_in.operand_b))
    else $error("subtract borrow wrong");

  a_rotate_carry: assert property (
    (exec_valid_in && exec_in.op == CSF_ROTATE_RIGHT_INSTR) |=>
      flags[CSF_BIT_CARRY] == $past(exec_in.operand_a[0]) &&
      result[7] == $past(flags[CSF_BIT_CARRY]))
    else $error("rotate right carry wrong");

  a_dest_blocked: assert property (
    (exec_valid_in && exec_in.op == CSF_REG_CLEAR_INSTR &&
     exec_in.dest_status && !sw_flag_write) |=>
      flags[CSF_BIT_ZERO] && $stable(flags[1:0]))
    else $error("clear of status wrote blocked flags");

  a_dest_write: assert property (
    (exec_valid_in && exec_in.op == CSF_MOVE_W_TO_REG_INSTR &&
     exec_in.dest_status) |=>
      flags[2:0] == $past(exec_in.operand_a[2:0]) &&
      flags[4] == ($past(flags[4]) && !$past(watchdog_timeout_in)) &&
      $stable(flags[3]))
    else $error("move to status not applied");

  a_flags_untouched: assert property (
    (exec_valid_in && exec_in.op == CSF_BIT_SET_INSTR &&
     !exec_in.dest_status && !sw_flag_write) |=> $stable(flags[2:0]))
    else $error("neutral instruction changed flags");

endmodule

// file: dv/csf_exec_model.sv
`timescale 1ns/1ps
module csf_exec_model
  import csf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire csf_exec_t cmd_in,
  input wire logic wdt_in,
  output logic exec_valid_out,
  output csf_exec_t exec_out,
  output logic watchdog_timeout_out
);
  // Idle operands toggle so a stale instruction never looks valid
  always_ff @(posedge clk_sys_in) begin
    exec_valid_out <= go_in & ~rst_in;
    watchdog_timeout_out <= wdt_in & ~rst_in;
    if (rst_in) begin
      exec_out <= '0;
    end else if (go_in) begin
      exec_out <= cmd_in;
    end else begin
      exec_out.operand_a <= ~exec_out.operand_a;
      exec_out.operand_b <= ~exec_out.operand_b;
    end
  end
endmodule

// file: dv/core_status_flags_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("BAD %s exp %0h got %0h", n, e, g); \
  end \
end
module core_status_flags_bench
  import csf_pkg::*;
;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic go = 1'h0;
  logic wdt = 1'h0;
  csf_exec_t cmd = '0;
  logic exec_valid_in;
  logic watchdog_timeout_in;
  csf_exec_t exec_in;
  logic [7:0] flags_out;
  logic [7:0] result_out;
  logic result_valid_out;
  logic [7:0] s_axi_awaddr_in = 8'h00;
  logic [7:0] s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 1'h0;
  logic s_axi_wvalid_in = 1'h0;
  logic s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0;
  logic s_axi_rready_in = 1'h0;
  logic s_axi_awready_out;
  logic s_axi_wready_out;
  logic s_axi_bvalid_out;
  logic s_axi_arready_out;
  logic s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out;
  logic [1:0] s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  int failures = 0;
  int checks_done = 0;
  int seed = 56;
  logic [7:0] exp_flags = 8'h18;
  logic [7:0] exp_res = 8'h00;
  logic [31:0] u;
  logic [31:0] rd;
  logic [1:0] rsp;

  always #5 clk_sys_in = ~clk_sys_in;

  csf_exec_model partner (.*, .go_in(go), .cmd_in(cmd), .wdt_in(wdt),
    .exec_valid_out(exec_valid_in), .exec_out(exec_in),
    .watchdog_timeout_out(watchdog_timeout_in));
  core_status_flags dut (.*);

  function automatic logic [15:0] predict(input logic [7:0] f,
                                          input csf_exec_t c, input logic w);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [2:0] af;
    logic [7:0] n;
    s = 9'h000;
    h = 5'h00;
    r = c.operand_a;
    af = 3'h0;
    n = f;
    case (c.op)
      CSF_ADD_REG_INSTR, CSF_ADD_LITERAL_INSTR: begin
        s = c.operand_a + c.operand_b;
        h = c.operand_a[3:0] + c.operand_b[3:0];
        af = 3'h7;
      end
      CSF_SUB_LITERAL_INSTR, CSF_SUB_REG_INSTR: begin
        s = c.operand_a + {1'h0, ~c.operand_b} + 9'h001;
        h = c.operand_a[3:0] + {1'h0, ~c.operand_b[3:0]} + 5'h01;
        af = 3'h7;
      end
      CSF_AND_INSTR: r = c.operand_a & c.operand_b;
      CSF_OR_INSTR: r = c.operand_a | c.operand_b;
      CSF_XOR_INSTR: r = c.operand_a ^ c.operand_b;
      CSF_INC_INSTR: r = c.operand_a + 8'h01;
      CSF_DEC_INSTR: r = c.operand_a - 8'h01;
      CSF_REG_CLEAR_INSTR: r = 8'h00;
      CSF_ROTATE_RIGHT_INSTR: s = {c.operand_a[0], f[0], c.operand_a[7:1]};
      CSF_ROTATE_LEFT_INSTR: s = {c.operand_a[7], c.operand_a[6:0], f[0]};
      CSF_BIT_CLEAR_INSTR: r = c.operand_a & ~(8'h01 << c.operand_b[2:0]);
      CSF_BIT_SET_INSTR: r = c.operand_a | (8'h01 << c.operand_b[2:0]);
      CSF_NIBBLE_SWAP_INSTR: r = {c.operand_a[3:0], c.operand_a[7:4]};
      default: r = c.operand_a;
    endcase
    if (c.op inside {CSF_AND_INSTR, CSF_OR_INSTR, CSF_XOR_INSTR,
                     CSF_INC_INSTR, CSF_DEC_INSTR, CSF_REG_CLEAR_INSTR}) begin
      af = 3'h4;
    end
    if (c.op inside {CSF_ROTATE_RIGHT_INSTR, CSF_ROTATE_LEFT_INSTR}) begin
      af = 3'h1;
    end
    if (af[0]) begin
      r = s[7:0];
    end
    if (c.dest_status && af == 3'h0 && !(c.op inside {CSF_NOP, CSF_SLEEP_INSTR,
        CSF_ADD_LITERAL_INSTR, CSF_SUB_LITERAL_INSTR,
        CSF_WATCHDOG_CLEAR_INSTR})) begin
      n[2:0] = r[2:0];
    end
    if (af[2]) begin
      n[2] = (r == 8'h00);
    end
    if (af[1]) begin
      n[1] = h[4];
    end
    if (af[0]) begin
      n[0] = s[8];
    end
    if (w) begin
      n[4] = 1'h0;
    end
    // Set beats a same-cycle timeout clear
    if (c.op == CSF_WATCHDOG_CLEAR_INSTR) begin
      n[4:3] = 2'h3;
    end
    if (c.op == CSF_SLEEP_INSTR) begin
      n[4:3] = 2'h2;
    end
    return {r, n};
  endfunction

  task automatic run(input csf_op_t o, input logic [7:0] a,
                     input logic [7:0] b, input logic d, input logic w);
    logic [15:0] e;
    e = predict(exp_flags, '{o, a, b, d}, w);
    @(posedge clk_sys_in);
    cmd <= '{o, a, b, d};
    go <= 1'h1;
    wdt <= w;
    @(posedge clk_sys_in);
    go <= 1'h0;
    wdt <= 1'h0;
    @(posedge clk_sys_in);
    #1;
    `CHK("flags", e[7:0], flags_out)
    `CHK("pulse", 1'h1, result_valid_out)
    `CHK("result", e[15:8], result_out)
    exp_res = e[15:8];
    exp_flags = e[7:0];
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st, output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= st;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge clk_sys_in);
      if (!ta && s_axi_awready_out === 1'h1) begin
        ta = 1'h1;
        s_axi_awvalid_in <= 1'h0;
      end
      if (!tw && s_axi_wready_out === 1'h1) begin
        tw = 1'h1;
        s_axi_wvalid_in <= 1'h0;
      end
    end
    do @(posedge clk_sys_in); while (s_axi_bvalid_out !== 1'h1);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'h0;
    #1;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'h1);
    s_axi_arvalid_in <= 1'h0;
    do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'h1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'h0;
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Budget well above the roughly 1200 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (9) @(posedge clk_sys_in);
    #1;
    `CHK("reset", 8'h18, flags_out)
    @(posedge clk_sys_in);
    rst_in <= 1'h0;
    run(CSF_ADD_REG_INSTR, 8'hff, 8'h01, 1'h0, 1'h0);
    run(CSF_ADD_LITERAL_INSTR, 8'h08, 8'h08, 1'h0, 1'h0);
    run(CSF_SUB_REG_INSTR, 8'h05, 8'h05, 1'h0, 1'h0);
    run(CSF_SUB_LITERAL_INSTR, 8'h00, 8'h01, 1'h0, 1'h0);
    run(CSF_ROTATE_RIGHT_INSTR, 8'h01, 8'h00, 1'h1, 1'h0);
    run(CSF_ROTATE_LEFT_INSTR, 8'h80, 8'h00, 1'h0, 1'h0);
    run(CSF_MOVE_W_TO_REG_INSTR, 8'hfd, 8'h00, 1'h1, 1'h0);
    run(CSF_REG_CLEAR_INSTR, 8'h5a, 8'h00, 1'h1, 1'h0);
    run(CSF_BIT_SET_INSTR, 8'h00, 8'h01, 1'h1, 1'h0);
    run(CSF_NOP, 8'h33, 8'h00, 1'h0, 1'h1);
    run(CSF_SLEEP_INSTR, 8'h00, 8'h00, 1'h0, 1'h1);
    run(CSF_WATCHDOG_CLEAR_INSTR, 8'h00, 8'h00, 1'h0, 1'h1);
    axw(CSF_FLAGS_OFFSET, 32'hffff_ffff, 4'hf, rsp);
    exp_flags[2:0] = 3'h7;
    `CHK("bresp", CSF_RESP_OKAY, rsp)
    `CHK("wrflags", exp_flags, flags_out)
    axr(CSF_FLAGS_OFFSET, rd, rsp);
    `CHK("rdflags", {24'h00_0000, exp_flags}, rd)
    axw(CSF_RESULT_OFFSET, 32'hffff_ffff, 4'hf, rsp);
    axr(CSF_RESULT_OFFSET, rd, rsp);
    `CHK("rdres", {24'h00_0000, exp_res}, rd)
    axw(8'h08, 32'h0000_0000, 4'hf, rsp);
    `CHK("badwr", CSF_RESP_SLVERR, rsp)
    `CHK("badwrflags", exp_flags, flags_out)
    axr(8'h0c, rd, rsp);
    `CHK("badrd", {CSF_RESP_SLVERR, 32'h0000_0000}, {rsp, rd})
    for (int i = 0; i < 300; i++) begin
      u = $random(seed);
      run(csf_op_t'(5'(u % 19)), u[15:8], u[23:16], u[24],
          u[27:25] == 3'h0);
      if (u[31:29] == 3'h0) begin
        axw(CSF_FLAGS_OFFSET, u, u[28:25], rsp);
        if (u[25]) begin
          exp_flags[2:0] = u[2:0];
        end
        `CHK("rwflags", exp_flags, flags_out)
        axr(CSF_FLAGS_OFFSET, rd, rsp);
        `CHK("rrflags", {24'h00_0000, exp_flags}, rd)
      end
    end
    end_of_test();
  end
endmodule
